// ---- rtl/fw_pkg.sv ----
package fw_pkg;

   // ************************************************************
   // array geometry
   // ************************************************************
   localparam int          ADDR_W      = 9;
   localparam int          DATA_W      = 8;
   localparam int          MEM_DEPTH   = 512;

   // ************************************************************
   // opcodes: fixed part of read and write, upper address in bit 3
   // ************************************************************
   localparam logic [7:0]  OP_RW_MASK  = 8'hf7;   // opcode bits other than the address bit
   localparam logic [7:0]  OP_WRITE    = 8'h02;
   localparam logic [7:0]  OP_READ     = 8'h03;
   localparam logic [7:0]  OP_WRITE_HI = 8'h0a;
   localparam int          OP_ABIT     = 3;       // opcode bit holding address bit 8
   localparam logic [7:0]  OP_SET_WL   = 8'h06;   // set_write_latch_cmd, plain default
   localparam logic [7:0]  OP_CLR_WL   = 8'h04;   // clear_write_latch_cmd, plain default
   localparam logic [7:0]  OP_STAT_RD  = 8'h05;   // status read, plain default
   localparam logic [7:0]  OP_STAT_WR  = 8'h01;   // status_write_cmd, plain default

   // ************************************************************
   // status register layout
   // ************************************************************
   localparam int          ST_WEL      = 1;
   localparam int          ST_BP_LO    = 2;
   localparam int          ST_BP_HI    = 3;
   localparam logic [7:0]  ST_RESET    = 8'h00;
   localparam logic [2:0]  BIT_LAST    = 3'h7;

   // ************************************************************
   // serial pins, grouped
   // ************************************************************
   typedef struct packed {
      logic cs_n;
      logic sck;
      logic si;
   } fw_pins_t;

   localparam logic [2:0]  PIN_IDLE    = 3'h4;    // deselected, clock low, data low

   typedef enum logic [2:0] {
      PH_CMD   = 3'b000,
      PH_ADDR  = 3'b001,
      PH_WDATA = 3'b010,
      PH_RDATA = 3'b011,
      PH_STWR  = 3'b100,
      PH_STRD  = 3'b101,
      PH_IDLE  = 3'b110
   } fw_phase_t;

endpackage

// ---- rtl/fw_latch_status.sv ----
`timescale 1ns/1ps
// Function
// - set command sets the write latch
// - status bit 1 shows the latch, reset zero
// - status write does not load the latch from data bit 1
// - completed lower-half or status write clears the latch
// - status bit 0 reads zero always
// - status bits 7 to 4 read zero
// - block protect bits at status 3:2
// - opcode bit 3 carries address bit 8
// - read 0000A011, write 0000A010 opcode forms
// - lower half: write 0x02, read 0x03
// - upper-half write leaves latch set
// - upper half: write 0x0a, read 0x0b
// - clear command clears the latch
module fw_latch_status (
   input  wire logic             core_clk,
   input  wire logic             rst,
   input  wire fw_pkg::fw_pins_t pins,
   output logic                  so_o_r,
   output logic                  so_oe_n_r,
   output logic [7:0]            status_r
);
   import fw_pkg::*;

   // ************************************************************
   // pin synchronisers and agreement filter
   // ************************************************************
   logic [2:0]           s1_r;
   logic [2:0]           s2_r;
   logic [2:0]           s3_r;
   logic [2:0]           flt_r;
   logic [2:0]           flt_q_r;
   fw_pins_t             pf;
   fw_pins_t             pq;

   // three stages; second stage feeds the third and the filter
   always_ff @(posedge core_clk) begin
      if (rst) begin
         s1_r <= PIN_IDLE;
         s2_r <= PIN_IDLE;
         s3_r <= PIN_IDLE;
         flt_q_r <= PIN_IDLE;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
         flt_q_r <= flt_r;
      end
   end

   // a pin changes once the second and third stages agree
   for (genvar g = 0; g < 3; g++) begin : g_flt
      always_ff @(posedge core_clk) begin
         if (rst) begin
            flt_r[g] <= PIN_IDLE[g];
         end else if (s2_r[g] == s3_r[g]) begin
            flt_r[g] <= s3_r[g];
         end
      end
   end

   assign pf = flt_r;
   assign pq = flt_q_r;

   // ************************************************************
   // edge decode
   // ************************************************************
   wire sel       = ~pf.cs_n;
   wire frame_end = pf.cs_n & ~pq.cs_n;
   wire sck_rise  = sel & pf.sck & ~pq.sck;     // sample edge, both modes
   wire sck_fall  = sel & ~pf.sck & pq.sck;     // shift-out edge

   // ************************************************************
   // state
   // ************************************************************
   logic [7:0]           mem [MEM_DEPTH];
   fw_phase_t            phase_r;
   logic [2:0]           bit_cnt_r;
   logic [7:0]           rx_r;
   logic [7:0]           tx_r;
   logic [7:0]           op_r;
   logic [ADDR_W-1:0]    addr_r;
   logic                 wel_r;
   logic [1:0]           bp_r;
   logic                 wr_done_r;

   wire [7:0]        rx_byte   = {rx_r[6:0], pf.si};         // msb first
   wire              byte_done = sck_rise & (bit_cnt_r == BIT_LAST);
   wire              is_rw_wr  = (rx_byte & OP_RW_MASK) == OP_WRITE;
   wire              is_rw_rd  = (rx_byte & OP_RW_MASK) == OP_READ;
   wire [ADDR_W-1:0] addr_full = {op_r[OP_ABIT], rx_byte};
   wire [ADDR_W-1:0] addr_inc  = addr_r + 1'b1;
   wire [7:0]        stat_val  = {4'h0, bp_r, wel_r, 1'b0};
   wire              upper_wr  = (op_r == OP_WRITE_HI);
   wire              cmd_done  = byte_done & (phase_r == PH_CMD);
   wire              st_wr_ok  = byte_done & (phase_r == PH_STWR) & wel_r;
   wire              mem_wr_ok = byte_done & (phase_r == PH_WDATA) & wel_r;

   // next phase after the command byte
   fw_phase_t cmd_phase;
   assign cmd_phase = (is_rw_wr | is_rw_rd)     ? PH_ADDR :
                      (rx_byte == OP_STAT_WR)   ? PH_STWR :
                      (rx_byte == OP_STAT_RD)   ? PH_STRD : PH_IDLE;

   // bit counter, receive shift and phase sequencing
   always_ff @(posedge core_clk) begin
      if (rst || !sel) begin
         phase_r   <= PH_CMD;
         bit_cnt_r <= 3'h0;
         rx_r      <= 8'h00;
      end else if (sck_rise) begin
         bit_cnt_r <= bit_cnt_r + 3'h1;
         rx_r      <= rx_byte;
         if (byte_done) begin
            case (phase_r)
               PH_CMD:   phase_r <= cmd_phase;
               PH_ADDR:  phase_r <= (op_r[0]) ? PH_RDATA : PH_WDATA;
               PH_STWR:  phase_r <= PH_IDLE;
               default:  phase_r <= phase_r;
            endcase
         end
      end
   end

   // opcode and address capture, address walks through the array
   always_ff @(posedge core_clk) begin
      if (rst) begin
         op_r   <= 8'h00;
         addr_r <= '0;
      end else if (cmd_done) begin
         op_r   <= rx_byte;
      end else if (byte_done && phase_r == PH_ADDR) begin
         addr_r <= addr_full;
      end else if (byte_done && (phase_r == PH_WDATA || phase_r == PH_RDATA)) begin
         addr_r <= addr_inc;
      end
   end

   // array write, refused while the latch is clear
   always_ff @(posedge core_clk) begin
      if (mem_wr_ok) begin
         mem[addr_r] <= rx_byte;
      end
   end

   // transmit shift: loaded on byte boundaries, shifted on falling edges
   always_ff @(posedge core_clk) begin
      if (rst) begin
         tx_r   <= 8'h00;
         so_o_r <= 1'b0;
      end else if (byte_done) begin
         tx_r <= (phase_r == PH_ADDR)  ? mem[addr_full] :
                 (phase_r == PH_RDATA) ? mem[addr_inc]  :
                 (cmd_done && cmd_phase == PH_STRD) ? stat_val :
                 (phase_r == PH_STRD)  ? stat_val : 8'h00;
      end else if (sck_fall) begin
         so_o_r <= tx_r[7];
         tx_r   <= {tx_r[6:0], 1'b0};
      end
   end

   // output driven only during read phases, enable active low
   always_ff @(posedge core_clk) begin
      if (rst) begin
         so_oe_n_r <= 1'b1;
      end else begin
         so_oe_n_r <= ~(sel & (phase_r == PH_RDATA || phase_r == PH_STRD));
      end
   end

   // block protect bits and write-completion flag
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bp_r      <= ST_RESET[ST_BP_HI:ST_BP_LO];
         wr_done_r <= 1'b0;
      end else if (frame_end) begin
         wr_done_r <= 1'b0;
      end else begin
         if (st_wr_ok) begin
            bp_r <= rx_byte[ST_BP_HI:ST_BP_LO];
         end
         if (st_wr_ok || mem_wr_ok) begin
            wr_done_r <= 1'b1;
         end
      end
   end

   // write latch: acts when the frame closes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         wel_r <= ST_RESET[ST_WEL];
      end else if (frame_end) begin
         if (op_r == OP_SET_WL) begin
            wel_r <= 1'b1;
         end else if (op_r == OP_CLR_WL) begin
            wel_r <= 1'b0;
         end else if (wr_done_r && !upper_wr) begin
            wel_r <= 1'b0;
         end
      end
   end

   // status image, latch in bit 1, unused bits zero
   always_ff @(posedge core_clk) begin
      if (rst) begin
         status_r <= ST_RESET;
      end else begin
         status_r <= stat_val;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_set_latch;
      @(posedge core_clk) disable iff (rst)
      frame_end && op_r == OP_SET_WL |=> wel_r ##1 status_r[ST_WEL];
   endproperty
   a_set_latch: assert property (p_set_latch) else $error("latch not set");

   property p_stat_mirror;
      @(posedge core_clk) disable iff (rst)
      status_r[ST_WEL] == $past(wel_r);
   endproperty
   a_stat_mirror: assert property (p_stat_mirror) else $error("status bit1 wrong");

   property p_stwr_keeps;
      @(posedge core_clk) disable iff (rst)
      st_wr_ok |=> $stable(wel_r);
   endproperty
   a_stwr_keeps: assert property (p_stwr_keeps) else $error("latch moved");

   property p_wr_clears;
      @(posedge core_clk) disable iff (rst)
      frame_end && wr_done_r && !upper_wr && op_r != OP_SET_WL |=> !wel_r;
   endproperty
   a_wr_clears: assert property (p_wr_clears) else $error("latch not cleared");

   property p_zero_bits;
      @(posedge core_clk) disable iff (rst)
      status_r[0] == 1'b0 && status_r[7:4] == 4'h0;
   endproperty
   a_zero_bits: assert property (p_zero_bits) else $error("fixed bits set");

   property p_bp_write;
      @(posedge core_clk) disable iff (rst)
      st_wr_ok |=> bp_r == $past(rx_byte[ST_BP_HI:ST_BP_LO])
               ##1 status_r[ST_BP_HI:ST_BP_LO] == bp_r;
   endproperty
   a_bp_write: assert property (p_bp_write) else $error("protect bits wrong");

   property p_addr_msb;
      @(posedge core_clk) disable iff (rst)
      byte_done && phase_r == PH_ADDR |=> addr_r[ADDR_W-1] == op_r[OP_ABIT];
   endproperty
   a_addr_msb: assert property (p_addr_msb) else $error("address bit 8 wrong");

   property p_upper_keeps;
      @(posedge core_clk) disable iff (rst)
      frame_end && upper_wr && wel_r |=> wel_r [*2];
   endproperty
   a_upper_keeps: assert property (p_upper_keeps) else $error("upper write cleared");

   property p_clr_latch;
      @(posedge core_clk) disable iff (rst)
      frame_end && op_r == OP_CLR_WL |=> !wel_r;
   endproperty
   a_clr_latch: assert property (p_clr_latch) else $error("latch not cleared");

   property p_oe_sel;
      @(posedge core_clk) disable iff (rst)
      !so_oe_n_r |-> $past(sel);
   endproperty
   a_oe_sel: assert property (p_oe_sel) else $error("drive while idle");

endmodule

// ---- verification/fw_host_model.sv ----
`timescale 1ns/1ps
// ************************************************************
// spi host model: modes 0 and 3, msb first, link clock parked at cpol
// ************************************************************
module fw_host_model (
   output fw_pkg::fw_pins_t pins,
   input  wire logic        so,
   input  wire logic        so_oe_n
);
   import fw_pkg::*;

   logic                    cpol;

   // deselected with clock low until the first frame
   initial begin
      pins = PIN_IDLE;
      cpol = 1'b0;
   end

   // change clock polarity while deselected; mode 3 parks the clock high
   task automatic set_mode(input logic m);
      cpol = m;
      pins.sck = m;
      #200;
   endtask

   // one byte each way; reply sampled late in the high phase
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         if (cpol) begin
            pins.sck = 1'b0;             // mode 3: falling edge opens each bit
         end
         pins.si = tx[i];
         #80 pins.sck = 1'b1;
         #70 rx[i] = so_oe_n ? ~so : so;
         #10;
         if (!cpol) begin
            pins.sck = 1'b0;             // mode 0: clock parked low between bits
         end
      end
   endtask

   // select, n bytes from the top of tx, deselect, gap
   task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
      logic [7:0] b;
      rx = '0;
      pins.cs_n = 1'b0;
      #80;
      for (int k = 0; k < n; k++) begin
         xfer(tx[31-8*k -: 8], b);
         rx = {rx[23:0], b};
      end
      #40 pins.cs_n = 1'b1;
      pins.si = ~pins.si; // released data line does not hold its level
      #200;
   endtask
endmodule

// ---- verification/tb_fw_latch_status.sv ----
`timescale 1ns/1ps
module tb_fw_latch_status;
   import fw_pkg::*;

   logic             core_clk;
   logic             rst;
   fw_pins_t         pins;
   logic             so_o_r;
   logic             so_oe_n_r;
   logic [7:0]       status_r;
   logic [31:0]      rx;
   int               error_cnt;
   int               total_checks;
   int               cyc;

   // ************************************************************
   // clock, reset, instances
   // ************************************************************
   initial begin
      core_clk = 1'b0;
   end
   always #10 core_clk = ~core_clk;

   fw_latch_status fw_latch_status_inst (
      .core_clk  (core_clk),
      .rst       (rst),
      .pins      (pins),
      .so_o_r    (so_o_r),
      .so_oe_n_r (so_oe_n_r),
      .status_r  (status_r)
   );

   fw_host_model fw_host_model_inst (
      .pins    (pins),
      .so      (so_o_r),
      .so_oe_n (so_oe_n_r)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic send(input logic [31:0] tx, input int n);
      fw_host_model_inst.frame(tx, n, rx);
   endtask

   // status seen on the port and through the status read opcode
   task automatic stat(input logic [7:0] exp);
      check("status_r", exp, status_r);
      send(32'h05000000, 2);
      check("status read", exp, rx[7:0]);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      check("status_r", 8'h00, status_r);
      check("so_oe_n_r", 8'h01, {7'h00, so_oe_n_r});
   endtask

   task automatic t_status();
      send(32'h06000000, 1);
      stat(8'h02);
      send(32'h01ff0000, 2);
      stat(8'h0c);
      send(32'h01000000, 2);
      stat(8'h0c);
      send(32'h06000000, 1);
      send(32'h01f70000, 2);
      stat(8'h04);
   endtask

   task automatic t_array();
      send(32'h06000000, 1);
      send(32'h0210a500, 3);
      stat(8'h04);
      send(32'h03100000, 3);
      check("read 010", 8'ha5, rx[7:0]);
      send(32'h06000000, 1);
      send(32'h0a205a00, 3);
      stat(8'h06);
      send(32'h0a213c00, 3);
      send(32'h0220c300, 3);
      stat(8'h04);
      send(32'h0b200000, 4);
      check("read 120", 8'h5a, rx[15:8]);
      check("read 121", 8'h3c, rx[7:0]);
      send(32'h03200000, 3);
      check("read 020", 8'hc3, rx[7:0]);
   endtask

   task automatic t_clear();
      send(32'h06000000, 1);
      send(32'h04000000, 1);
      stat(8'h04);
      send(32'h02200000, 3);
      send(32'h03200000, 3);
      check("refused write", 8'hc3, rx[7:0]);
   endtask

   // mode 3: clock parked high, same sampling edge
   task automatic t_mode3();
      fw_host_model_inst.set_mode(1'b1);
      send(32'h06000000, 1);
      send(32'h0aff7700, 3);
      stat(8'h06);
      send(32'h04000000, 1);
      stat(8'h04);
      send(32'h0bff0000, 3);
      check("read 1ff", 8'h77, rx[7:0]);
      fw_host_model_inst.set_mode(1'b0);
   endtask

   // reset in mid-run clears latch and protect bits
   task automatic t_rst_mid();
      send(32'h06000000, 1);
      rst = 1'b1;
      repeat (2) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      stat(8'h00);
   endtask

   // ************************************************************
   // main sequence and hang guard
   // ************************************************************
   initial begin
      rst = 1'b1;
      error_cnt = 0;
      total_checks = 0;
      repeat (10) @(posedge core_clk);
      #1 rst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      t_reset();
      t_status();
      t_array();
      t_clear();
      t_mode3();
      t_rst_mid();
      end_sim();
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         error_cnt++;
         end_sim();
      end
   end
endmodule
